// ==== verilog/rivu_defines.svh ====
// constants of the reset, interrupt-vector and stack-pointer unit
// assumes a system clock of 8 ns and an on-chip watchdog oscillator
`ifndef RIVU_DEFINES_SVH
`define RIVU_DEFINES_SVH

// ==============================================
// i/o addresses
`define RIVU_ADDR_STATUS    6'h3F
`define RIVU_ADDR_SP_HIGH   6'h3E
`define RIVU_ADDR_SP_LOW    6'h3D
`define RIVU_ADDR_EXT_MASK  6'h3B

// ==============================================
// field positions and reset values
`define RIVU_GIE_BIT        7
`define RIVU_EXT1_BIT       7
`define RIVU_EXT0_BIT       6
`define RIVU_EXT_MASK_RW    8'hC0
`define RIVU_EXT_MASK_RESET 8'h00
`define RIVU_SP_RESET       16'h0000
`define RIVU_GIE_RESET      1'b0

// ==============================================
// vectors
`define RIVU_VEC_RESET      12'h000
`define RIVU_VEC_FIRST_IRQ  12'h001
`define RIVU_VEC_LAST_IRQ   12'h00C
`define RIVU_NUM_SRC        12

// ==============================================
// timing
`define RIVU_SYS_PERIOD_NS  8
`define RIVU_WDOG_PERIOD_NS 1000
`define RIVU_T_POR_MS       3
`define RIVU_T_TOUT_SLOW_MS 16
`define RIVU_T_TOUT_FAST_MS 1.1
`define RIVU_NS_PER_MS      1000000

`endif

// ==== verilog/rivu_pkg.sv ====
// types of the reset, interrupt-vector and stack-pointer unit
// assumes rivu_defines.svh is compiled in the same unit
`default_nettype none
`include "rivu_defines.svh"

package rivu_pkg;

    // ==============================================
    // reset sequencer states
    typedef enum logic [2:0] {RS_POR, RS_HOLD, RS_WDT, RS_TOUT, RS_RUN} rst_state_e;

    // ==============================================
    // core to unit
    typedef struct packed {
        logic       boundary;
        logic       push;
        logic       pop;
        logic       call;
        logic       ret;
        logic       irq_return;
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } cpu_req_s;

    // ==============================================
    // unit to core and sources
    typedef struct packed {
        logic                      core_reset;
        logic                      irq_take;
        logic [11:0]               vector;
        logic [`RIVU_NUM_SRC-1:0]  flag_clr;
        logic [7:0]                rdata;
        logic [15:0]               sp;
        logic                      gie;
    } cpu_rsp_s;

    // ==============================================
    // whole module state
    typedef struct packed {
        rst_state_e  st;
        logic [15:0] cnt;
        logic [15:0] div;
        logic        tick;
        logic [2:0]  pin_sync;
        logic        pin_lvl;
        logic        fast;
        logic [7:0]  ext_mask;
        cpu_rsp_s    rsp;
    } state_s;

endpackage : rivu_pkg

`default_nettype wire

// ==== verilog/reset_interrupt_vector_unit.sv ====
// reset sequencing, interrupt vectoring and stack pointer of an 8-bit core
// assumes core and interrupt sources on clk_sys_in; reset pin asynchronous
`timescale 1ns/1ns
`default_nettype none
`include "rivu_defines.svh"

module reset_interrupt_vector_unit
    import rivu_pkg::*;
#(
    parameter int WDOG_DIV   = `RIVU_WDOG_PERIOD_NS / `RIVU_SYS_PERIOD_NS,
    parameter int POR_TICKS  = `RIVU_T_POR_MS * `RIVU_NS_PER_MS / `RIVU_WDOG_PERIOD_NS,
    parameter int SLOW_TICKS = `RIVU_T_TOUT_SLOW_MS * `RIVU_NS_PER_MS / `RIVU_WDOG_PERIOD_NS,
    parameter int FAST_TICKS = int'(`RIVU_T_TOUT_FAST_MS * `RIVU_NS_PER_MS / `RIVU_WDOG_PERIOD_NS)
) (
    input  wire logic                     clk_sys_in,
    input  wire logic                     nrst_in,
    input  wire logic                     ext_reset_n_in,
    input  wire logic                     wdt_timeout_in,
    input  wire logic                     fast_start_fuse_in,
    input  wire cpu_req_s                 cpu_req_in,
    input  wire logic [`RIVU_NUM_SRC-1:0] src_flag_in,
    input  wire logic [`RIVU_NUM_SRC-1:0] src_enable_in,
    output var  cpu_rsp_s                 cpu_rsp_out
);

    // ==============================================
    // state and helpers
    state_s                    s_r;
    state_s                    s_nxt;
    logic [`RIVU_NUM_SRC-1:0]  en_w;
    logic [`RIVU_NUM_SRC-1:0]  pend_w;
    logic                      take_w;
    logic [3:0]                win_w;

    function automatic logic [3:0] prio(input logic [`RIVU_NUM_SRC-1:0] p);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = `RIVU_NUM_SRC - 1; i >= 0; i--) begin
            if (p[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : prio

    function automatic logic [15:0] sp_step(input logic [15:0] sp, input logic up, input logic two);
        logic [15:0] d;
        d = two ? 16'h0002 : 16'h0001;
        return up ? sp + d : sp - d;
    endfunction : sp_step

    // ==============================================
    // pending and acceptance
    always_comb begin
        en_w                 = src_enable_in;
        en_w[0]              = s_r.ext_mask[`RIVU_EXT0_BIT];
        en_w[1]              = s_r.ext_mask[`RIVU_EXT1_BIT];
    end
    assign pend_w = src_flag_in & en_w;
    assign take_w = (s_r.st == RS_RUN) && cpu_req_in.boundary
                    && s_r.rsp.gie && (|pend_w);
    assign win_w  = prio(pend_w);

    // ==============================================
    // next state
    always_comb begin
        s_nxt              = s_r;
        s_nxt.rsp.irq_take = 1'b0;
        s_nxt.rsp.flag_clr = '0;
        s_nxt.pin_sync     = {s_r.pin_sync[1:0], ext_reset_n_in};
        if (s_r.pin_sync[2] == s_r.pin_sync[1]) begin
            s_nxt.pin_lvl = s_r.pin_sync[1];
        end
        s_nxt.tick = 1'b0;
        if (s_r.div == 16'(WDOG_DIV - 1)) begin
            s_nxt.div  = 16'h0000;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div = s_r.div + 16'h0001;
        end

        case (s_r.st)
            RS_POR: begin
                s_nxt.fast = fast_start_fuse_in;
                if (s_r.tick) begin
                    s_nxt.cnt = s_r.cnt + 16'h0001;
                    if (s_r.cnt == 16'(POR_TICKS - 1)) begin
                        s_nxt.cnt = 16'h0000;
                        s_nxt.st  = s_r.pin_lvl ? RS_TOUT : RS_HOLD;
                    end
                end
            end
            RS_HOLD: begin
                s_nxt.cnt = 16'h0000;
                if (s_r.pin_lvl) begin
                    s_nxt.st = RS_TOUT;
                end
            end
            RS_WDT: begin
                s_nxt.cnt = 16'h0000;
                s_nxt.st  = RS_TOUT;
            end
            RS_TOUT: begin
                if (s_r.tick) begin
                    s_nxt.cnt = s_r.cnt + 16'h0001;
                    if (s_r.cnt == (s_r.fast ? 16'(FAST_TICKS - 1) : 16'(SLOW_TICKS - 1))) begin
                        s_nxt.cnt = 16'h0000;
                        s_nxt.st  = RS_RUN;
                    end
                end
            end
            RS_RUN: begin
                if (wdt_timeout_in) begin
                    s_nxt.st = RS_WDT;
                end
            end
            default: begin
                s_nxt.st = RS_POR;
            end
        endcase
        if (!s_r.pin_lvl && s_r.st != RS_POR) begin
            s_nxt.st  = RS_HOLD;
            s_nxt.cnt = 16'h0000;
        end

        if (s_r.st != RS_RUN) begin
            s_nxt.ext_mask   = `RIVU_EXT_MASK_RESET;
            s_nxt.rsp.sp     = `RIVU_SP_RESET;
            s_nxt.rsp.gie    = `RIVU_GIE_RESET;
            s_nxt.rsp.vector = `RIVU_VEC_RESET;
            s_nxt.rsp.rdata  = 8'h00;
        end else if (take_w) begin
            s_nxt.rsp.sp           = sp_step(s_r.rsp.sp, 1'b0, 1'b1);
            s_nxt.rsp.gie          = 1'b0;
            s_nxt.rsp.vector       = `RIVU_VEC_FIRST_IRQ + 12'(win_w);
            s_nxt.rsp.flag_clr     = '0;
            s_nxt.rsp.flag_clr[win_w] = 1'b1;
            s_nxt.rsp.irq_take     = 1'b1;
        end else begin
            if (cpu_req_in.push) begin
                s_nxt.rsp.sp = sp_step(s_r.rsp.sp, 1'b0, 1'b0);
            end else if (cpu_req_in.call) begin
                s_nxt.rsp.sp = sp_step(s_r.rsp.sp, 1'b0, 1'b1);
            end else if (cpu_req_in.pop) begin
                s_nxt.rsp.sp = sp_step(s_r.rsp.sp, 1'b1, 1'b0);
            end else if (cpu_req_in.ret || cpu_req_in.irq_return) begin
                s_nxt.rsp.sp = sp_step(s_r.rsp.sp, 1'b1, 1'b1);
            end
            if (cpu_req_in.irq_return) begin
                s_nxt.rsp.gie = 1'b1;
            end
            if (cpu_req_in.wr) begin
                case (cpu_req_in.addr)
                    `RIVU_ADDR_SP_HIGH: begin
                        s_nxt.rsp.sp[15:8] = cpu_req_in.wdata;
                    end
                    `RIVU_ADDR_SP_LOW: begin
                        s_nxt.rsp.sp[7:0] = cpu_req_in.wdata;
                    end
                    `RIVU_ADDR_EXT_MASK: begin
                        s_nxt.ext_mask = cpu_req_in.wdata & `RIVU_EXT_MASK_RW;
                    end
                    `RIVU_ADDR_STATUS: begin
                        s_nxt.rsp.gie = cpu_req_in.wdata[`RIVU_GIE_BIT];
                    end
                    default: begin
                    end
                endcase
            end
            if (cpu_req_in.rd) begin
                case (cpu_req_in.addr)
                    `RIVU_ADDR_SP_HIGH:  s_nxt.rsp.rdata = s_r.rsp.sp[15:8];
                    `RIVU_ADDR_SP_LOW:   s_nxt.rsp.rdata = s_r.rsp.sp[7:0];
                    `RIVU_ADDR_EXT_MASK: s_nxt.rsp.rdata = s_r.ext_mask;
                    `RIVU_ADDR_STATUS:   s_nxt.rsp.rdata = {s_r.rsp.gie, 7'h00};
                    default:          s_nxt.rsp.rdata = 8'h00;
                endcase
            end
        end
        s_nxt.rsp.core_reset = (s_nxt.st != RS_RUN);
    end

    // ==============================================
    // register
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_r.st       <= RS_POR;
            s_r.cnt      <= 16'h0000;
            s_r.div      <= 16'h0000;
            s_r.tick     <= 1'b0;
            s_r.pin_sync <= 3'h7;
            s_r.pin_lvl  <= 1'b1;
            s_r.fast     <= 1'b0;
            s_r.ext_mask <= `RIVU_EXT_MASK_RESET;
            s_r.rsp      <= '{core_reset: 1'b1, irq_take: 1'b0, vector: `RIVU_VEC_RESET,
                              flag_clr: '0, rdata: 8'h00, sp: `RIVU_SP_RESET, gie: `RIVU_GIE_RESET};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cpu_rsp_out = s_r.rsp;

    // ==============================================
    // assertions
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    a_sp_push_one: assert property (take_w == 1'b0 && s_r.st == RS_RUN && cpu_req_in.push
        && !cpu_req_in.wr |=> cpu_rsp_out.sp == $past(s_r.rsp.sp) - 16'h0001)
        else $error("push did not lower sp by one");
    a_sp_ret_two: assert property (!take_w && s_r.st == RS_RUN && cpu_req_in.ret
        && !cpu_req_in.push && !cpu_req_in.call && !cpu_req_in.pop && !cpu_req_in.wr
        |=> cpu_rsp_out.sp == $past(s_r.rsp.sp) + 16'h0002)
        else $error("return did not raise sp by two");
    a_take_entry: assert property (take_w |=> cpu_rsp_out.irq_take && !cpu_rsp_out.gie
        && cpu_rsp_out.sp == $past(s_r.rsp.sp) - 16'h0002)
        else $error("interrupt entry wrong");
    a_ext0_first: assert property (take_w && pend_w[0] |=> cpu_rsp_out.vector == 12'h001
        && cpu_rsp_out.flag_clr == 12'h001)
        else $error("request zero not preferred");
    a_flag_onehot: assert property (cpu_rsp_out.irq_take |-> $onehot(cpu_rsp_out.flag_clr)
        && cpu_rsp_out.flag_clr[cpu_rsp_out.vector[3:0] - 4'h1])
        else $error("flag clear not matching vector");
    a_gie_gate: assert property (!s_r.rsp.gie |=> !cpu_rsp_out.irq_take)
        else $error("interrupt taken while disabled");
    a_reset_state: assert property (cpu_rsp_out.core_reset ##1 cpu_rsp_out.core_reset
        |-> cpu_rsp_out.vector == 12'h000 && cpu_rsp_out.sp == 16'h0000 && !cpu_rsp_out.gie)
        else $error("reset did not restore registers");
    a_wdt_pulse: assert property (s_r.st == RS_RUN && wdt_timeout_in && s_r.pin_lvl
        |=> s_r.st == RS_WDT ##1 (s_r.st == RS_TOUT || s_r.st == RS_HOLD))
        else $error("watchdog pulse not one cycle");
    a_hold_core: assert property (s_r.st == RS_HOLD && !s_r.pin_lvl |=> cpu_rsp_out.core_reset)
        else $error("core released while pin low");
    a_tout_bound: assert property (s_r.st == RS_TOUT |-> s_r.cnt < 16'(SLOW_TICKS))
        else $error("delay counter overran");
    a_return_from_interrupt_gie: assert property (s_r.st == RS_RUN && !take_w && cpu_req_in.irq_return
        && !cpu_req_in.wr |=> cpu_rsp_out.gie)
        else $error("interrupt return left enable clear");
    a_mask_zero: assert property (s_r.st == RS_RUN && !take_w && cpu_req_in.rd
        && cpu_req_in.addr == 6'h3B |=> cpu_rsp_out.rdata[5:0] == 6'h00)
        else $error("mask reserved bits not zero");
    a_sph_read: assert property (s_r.st == RS_RUN && !take_w && cpu_req_in.rd
        && cpu_req_in.addr == 6'h3E |=> cpu_rsp_out.rdata == $past(s_r.rsp.sp[15:8]))
        else $error("sp high byte read wrong");
    a_short_pin: assert property (s_r.pin_lvl && $fell(s_r.pin_sync[1]) ##1 s_r.pin_sync[1]
        |-> s_r.pin_lvl)
        else $error("one-cycle pin glitch taken as reset");

    c_run: cover property (s_r.st == RS_TOUT ##1 s_r.st == RS_RUN);
    c_take: cover property (take_w ##1 cpu_rsp_out.irq_take);
    c_return_from_interrupt: cover property (cpu_rsp_out.irq_take ##[1:20] cpu_req_in.irq_return);
    c_wdt: cover property (s_r.st == RS_WDT);

endmodule : reset_interrupt_vector_unit

`default_nettype wire

// ==== bench/irq_source_model.sv ====
// flag side of the on-chip interrupt sources facing the vectoring unit
// assumes set requests and clear pulses arrive on clk_sys_in
`timescale 1ns/1ns
`default_nettype none
module irq_source_model (
    input  wire logic        clk_sys_in,
    input  wire logic        nrst_in,
    input  wire logic        core_reset_in,
    input  wire logic [11:0] set_in,
    input  wire logic [11:0] flag_clr_in,
    output logic      [11:0] flag_out
);
    logic [11:0] flag_r;
    // ==============================================
    // flags: set by events, cleared on vectoring or reset
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flag_r <= '0;
        end else if (core_reset_in) begin
            flag_r <= '0;
        end else begin
            flag_r <= (flag_r & ~flag_clr_in) | set_in;
        end
    end
    assign flag_out = flag_r;
endmodule : irq_source_model
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench of the reset, vector and stack-pointer unit
// assumes shortened timing parameters and the source model beside it
`timescale 1ns/1ns
`default_nettype none
module tb;
    import rivu_pkg::*;
    logic        clk_sys_in = 0, nrst_in = 0, ext_reset_n_in = 1, wdt_timeout_in = 0, fast_start_fuse_in = 0;
    cpu_req_s    cpu_req_in = '0;
    cpu_rsp_s    rsp;
    logic [11:0] src_en = '0, src_set = '0, src_flags, en;
    logic [5:0]  addrs [5] = '{6'h3B, 6'h3D, 6'h3E, 6'h3F, 6'h20};
    int          err_count = 0, tests_run = 0, cycles = 0;
    int          msp, mgie, mgimsk, mflags, n, k, idx, kind;
    int          dlt [6] = '{0, -1, 1, -2, 2, 2};

    always #4 clk_sys_in = ~clk_sys_in;

    reset_interrupt_vector_unit #(.WDOG_DIV(4), .POR_TICKS(5), .SLOW_TICKS(8), .FAST_TICKS(3)) dut (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ext_reset_n_in(ext_reset_n_in),
        .wdt_timeout_in(wdt_timeout_in), .fast_start_fuse_in(fast_start_fuse_in), .cpu_req_in(cpu_req_in),
        .src_flag_in(src_flags), .src_enable_in(src_en), .cpu_rsp_out(rsp));
    irq_source_model partner (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .core_reset_in(rsp.core_reset),
        .set_in(src_set), .flag_clr_in(rsp.flag_clr), .flag_out(src_flags));

    // ==============================================
    // checking and closing
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            finish_test();
        end
    end

    // ==============================================
    // core requests: 0 boundary 1 push 2 pop 3 call 4 ret 5 irq return 6 wr 7 rd
    task automatic op(input int kd, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        cpu_req_in <= {8'h80 >> kd, a, d};
        @(posedge clk_sys_in);
        cpu_req_in <= '0;
        #1;
    endtask : op
    function automatic logic [15:0] mreg(input logic [5:0] a);
        case (a)
            6'h3B: return 16'(mgimsk);
            6'h3D: return 16'(msp & 8'hFF);
            6'h3E: return 16'((msp >> 8) & 8'hFF);
            6'h3F: return 16'(mgie << 7);
            default: return 16'h0000;
        endcase
    endfunction : mreg
    task automatic rd_all;
        for (int i = 0; i < 5; i++) begin
            op(7, addrs[i], 8'h00);
            chk(16'(rsp.rdata), mreg(addrs[i]));
        end
        chk(rsp.sp, 16'(msp));
    endtask : rd_all
    task automatic wait_run(input int lo, input int hi);
        n = 0;
        while (rsp.core_reset !== 1'b0 && n < 400) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        chk(16'(n >= lo && n <= hi), 16'h0001);
        msp = 0;
        mgie = 0;
        mgimsk = 0;
        mflags = 0;
        chk(16'(rsp.vector), 16'h0000);
        rd_all();
    endtask : wait_run
    task automatic do_power(input logic fuse, input int pinhold, input int lo, input int hi);
        @(posedge clk_sys_in);
        nrst_in <= 0;
        fast_start_fuse_in <= fuse;
        ext_reset_n_in <= (pinhold == 0);
        repeat (10) @(posedge clk_sys_in);
        nrst_in <= 1;
        if (pinhold > 0) begin
            repeat (pinhold) @(posedge clk_sys_in);
            #1;
            chk(16'(rsp.core_reset), 16'h0001);
            @(posedge clk_sys_in);
            ext_reset_n_in <= 1;
        end
        wait_run(lo, hi);
        $display("power-on test done, fuse %0d hold %0d", fuse, pinhold);
    endtask : do_power

    initial begin
        k = $urandom(66);
        do_power(0, 0, 44, 72);
        do_power(1, 0, 20, 40);
        do_power(0, 100, 24, 48);
        // ==============================================
        // registers and stack arithmetic
        k = $urandom;
        op(6, 6'h3D, 8'h01);
        op(6, 6'h3E, 8'h00);
        op(6, 6'h3B, k[7:0]);
        msp = 1;
        mgimsk = k[7:0] & 8'hC0;
        rd_all();
        for (int i = 0; i < 24; i++) begin
            kind = (i == 0) ? 3 : 1 + $urandom % 5;
            op(kind, 6'h00, 8'h00);
            msp = (msp + dlt[kind]) & 16'hFFFF;
            if (kind == 5) mgie = 1;
            chk(rsp.sp, 16'(msp));
            chk(16'(rsp.gie), 16'(mgie));
        end
        $display("stack test done");
        // ==============================================
        // vectoring, one vector per pass
        for (int i = 0; i < 12; i++) begin
            k = $urandom;
            @(posedge clk_sys_in);
            src_set <= 12'((k << i) | (1 << i));
            src_en <= '0;
            @(posedge clk_sys_in);
            src_set <= '0;
            mflags |= (k << i) | (1 << i);
            op(6, 6'h3B, 8'h3F);
            op(6, 6'h3F, 8'h80);
            mgimsk = 0;
            mgie = 1;
            op(0, 6'h00, 8'h00);
            chk(16'(rsp.irq_take), 16'h0000);
            en = 12'(($urandom | 1) << i);
            @(posedge clk_sys_in);
            src_en <= en;
            op(6, 6'h3B, {en[1], en[0], k[5:0]});
            mgimsk = {en[1], en[0], 6'h00};
            idx = -1;
            for (int j = 11; j >= 0; j--) if (mflags[j] && en[j]) idx = j;
            op(0, 6'h00, 8'h00);
            msp = (msp - 2) & 16'hFFFF;
            mgie = 0;
            mflags &= ~(1 << idx);
            chk(16'(rsp.irq_take), 16'h0001);
            chk(16'(rsp.vector), 16'(idx + 1));
            chk(16'(rsp.flag_clr), 16'(1 << idx));
            chk(16'(rsp.gie), 16'h0000);
            chk(rsp.sp, 16'(msp));
            op(0, 6'h00, 8'h00);
            chk(16'(rsp.irq_take), 16'h0000);
            chk(16'(src_flags), 16'(mflags & 12'hFFF));
            op(5, 6'h00, 8'h00);
            msp = (msp + 2) & 16'hFFFF;
            mgie = 1;
            rd_all();
        end
        $display("vector test done");
        // ==============================================
        // pin reset and watchdog reset in run
        op(6, 6'h3E, 8'hA5);
        @(posedge clk_sys_in);
        ext_reset_n_in <= 0;
        repeat (8) @(posedge clk_sys_in);
        #1;
        chk(16'(rsp.core_reset), 16'h0001);
        @(posedge clk_sys_in);
        ext_reset_n_in <= 1;
        wait_run(24, 48);
        op(6, 6'h3D, 8'h5A);
        @(posedge clk_sys_in);
        wdt_timeout_in <= 1;
        @(posedge clk_sys_in);
        wdt_timeout_in <= 0;
        repeat (2) @(posedge clk_sys_in);
        #1;
        chk(16'(rsp.core_reset), 16'h0001);
        wait_run(20, 44);
        // a one-cycle dip on the pin must not reset the core
        @(posedge clk_sys_in);
        ext_reset_n_in <= 0;
        @(posedge clk_sys_in);
        ext_reset_n_in <= 1;
        repeat (6) @(posedge clk_sys_in);
        #1;
        chk(16'(rsp.core_reset), 16'h0000);
        $display("run reset test done");
        finish_test();
    end
endmodule : tb
`default_nettype wire
